//--- rtl/i2cs_slave.sv
// Notes on behaviour
// RULE_01: when enabled, idle until start, then shift eight address bits in.
// RULE_02: every incoming data bit is sampled on a rising serial clock.
// RULE_03: 7-bit mode compares own 6:0 with shifted 7:1; bit 0 is direction.
// RULE_04: control bit 10 clear selects 7-bit, set selects 10-bit addressing.
// RULE_05: 10-bit: first byte 11110 plus own 9:8, then byte own 7:0.
// RULE_06: own address register holds a full ten bits for both modes.
// RULE_07: software avoids reserved addresses; 0x78-0x7b are 10-bit prefixes.
// RULE_08: on match, acknowledge and pulse slave event at ninth falling edge.
// RULE_09: address match leaves receive buffer and its full flag untouched.
// RULE_10: direction one enters transmit, acks, holds clock until data written. Here the clock stays held after the write until the release bit is set.
// RULE_11: setting clock release frees the clock, then eight bits shift out.
// RULE_12: transmit data changes after falling edges, stable while clock high.
// RULE_13: after each sent byte, pulse slave event at ninth falling edge.
// RULE_14: double-buffered receive: finished byte moves to buffer with event.
// RULE_15: transmit uses one single register, no second buffer stage.
// RULE_16: control fully read/write; status low six bits read only. Here a zero written to control bit 12 clears it only while bit 6 is set.
// RULE_17: after repeated start in 10-bit mode, first byte alone re-addresses.
// RULE_18: bit-rate counter reloads from the baud reload register.
// RULE_19: buffer still full: no ack, keep old contents, still pulse event.
// RULE_20: transmit always stretches after ninth clock when transmit empty. Here a master nack sends the slave to idle with no stretch.
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module i2cs_slave (
   input  wire logic                CLOCK_I,
   input  wire logic                SRST_I,
   input  wire i2cs_pkg::i2cs_req_t BUS_I,
   output logic [15:0]              RDATA_O,
   input  wire logic                SCL_I,
   input  wire logic                SDA_I,
   output i2cs_pkg::i2cs_pins_t     PINS_O,
   output logic                     SLV_EVENT_O
);

   import i2cs_pkg::*;

   i2cs_st_t r_reg;
   i2cs_st_t r_next;

   logic scl;
   logic scl_rise;
   logic scl_fall;
   logic sda;
   logic start_det;
   logic stop_det;
   logic brg_tick;
   logic wr_ctrl;
   logic wr_tx;
   logic rd_rx;

   function automatic logic byte_end(input logic fall,
                                     input logic [3:0] cnt);
      byte_end = fall && (cnt == BITS_PER_BYTE);
   endfunction

   assign scl       = r_reg.scl_s[1];
   assign sda       = r_reg.sda_s[1];
   assign scl_rise  = r_reg.scl_s[1] & ~r_reg.scl_s[2];
   assign scl_fall  = ~r_reg.scl_s[1] & r_reg.scl_s[2];
   assign start_det = scl & r_reg.scl_s[2] & ~sda & r_reg.sda_s[2];
   assign stop_det  = scl & r_reg.scl_s[2] & sda & ~r_reg.sda_s[2];
   assign brg_tick  = (r_reg.brg == 16'h0000);
   assign wr_ctrl   = BUS_I.wr && (BUS_I.addr == REG_CTRL);
   assign wr_tx     = BUS_I.wr && (BUS_I.addr == REG_TX);
   assign rd_rx     = BUS_I.rd && (BUS_I.addr == REG_RX);

   always_comb begin
      logic rel_clr;
      logic ack;
      rel_clr = 1'b0;
      ack     = 1'b0;
      r_next  = r_reg;
      r_next.ev    = 1'b0;
      r_next.rdata = 16'h0000;
      r_next.scl_s = {r_reg.scl_s[1:0], SCL_I};
      r_next.sda_s = {r_reg.sda_s[1:0], SDA_I};

      // RULE_18: baud reload
      if (brg_tick) begin
         r_next.brg = r_reg.baud;
      end else begin
         r_next.brg = r_reg.brg - 16'h0001;
      end

      // register reads, answer one cycle later
      if (BUS_I.rd) begin
         unique case (BUS_I.addr)
            REG_CTRL: r_next.rdata = r_reg.ctrl;
            REG_STAT: r_next.rdata = {r_reg.stat_hi, r_reg.nack,
                                      (r_reg.fsm != ST_IDLE),
                                      r_reg.long_match, r_reg.rw,
                                      r_reg.rx_full, r_reg.tx_full};
            REG_OWN:  r_next.rdata = {6'h00, r_reg.own};
            REG_BAUD: r_next.rdata = r_reg.baud;
            REG_RX:   r_next.rdata = {8'h00, r_reg.rxbuf};
            default:  r_next.rdata = 16'h0000;
         endcase
      end
      if (rd_rx) begin
         r_next.rx_full = 1'b0;
      end

      // RULE_16: control read/write, status upper bits writable only
      if (BUS_I.wr) begin
         unique case (BUS_I.addr)
            REG_CTRL: begin
               r_next.ctrl = BUS_I.wdata;
               r_next.ctrl[CTRL_RELEASE] = BUS_I.wdata[CTRL_RELEASE] |
                  (~r_reg.ctrl[CTRL_RX_STRETCH_ENABLE] & r_reg.ctrl[CTRL_RELEASE]);
            end
            REG_STAT: r_next.stat_hi = BUS_I.wdata[15:STAT_RW_LSB];
            // RULE_06: full ten-bit own address
            REG_OWN:  r_next.own = BUS_I.wdata[9:0];
            REG_BAUD: r_next.baud = BUS_I.wdata;
            default:  ;
         endcase
      end

      // RULE_01: serial state machine
      if (!r_reg.ctrl[CTRL_ENABLE]) begin
         r_next.fsm     = ST_IDLE;
         r_next.sda_drv = 1'b0;
         r_next.prior   = 1'b0;
      end else if (start_det) begin
         r_next.fsm     = ST_ADDR;
         r_next.bitcnt  = 4'h0;
         r_next.sda_drv = 1'b0;
      end else if (stop_det) begin
         r_next.fsm     = ST_IDLE;
         r_next.sda_drv = 1'b0;
         r_next.prior   = 1'b0;
      end else begin
         unique case (r_reg.fsm)
            ST_IDLE: ;
            ST_ADDR, ST_ADDR2, ST_RX: begin
               // RULE_02: sample on rising clock
               if (scl_rise && r_reg.bitcnt != BITS_PER_BYTE) begin
                  r_next.shreg  = {r_reg.shreg[6:0], sda};
                  r_next.bitcnt = r_reg.bitcnt + 4'h1;
               end
               if (byte_end(scl_fall, r_reg.bitcnt)) begin
                  r_next.fsm    = ST_IDLE;
                  r_next.bitcnt = 4'h0;
                  // RULE_09: address bytes skip buffer
                  if (r_reg.fsm == ST_ADDR) begin
                     // RULE_04: address width select
                     if (!r_reg.ctrl[CTRL_A10]) begin
                        // RULE_03: seven-bit compare
                        if (r_reg.shreg[7:1] == r_reg.own[6:0]) begin
                           ack               = 1'b1;
                           r_next.rw         = r_reg.shreg[0];
                           r_next.long_match = 1'b0;
                           r_next.after = r_reg.shreg[0] ? ST_TX : ST_RX;
                        end
                     // RULE_05: long address prefix byte
                     end else if (r_reg.shreg[7:3] == LONG_PREFIX &&
                                  r_reg.shreg[2:1] == r_reg.own[9:8]) begin
                        if (!r_reg.shreg[0]) begin
                           ack               = 1'b1;
                           r_next.rw         = 1'b0;
                           r_next.long_match = 1'b0;
                           r_next.after      = ST_ADDR2;
                        // RULE_17: repeated start keeps long match
                        end else if (r_reg.prior) begin
                           ack          = 1'b1;
                           r_next.rw    = 1'b1;
                           r_next.after = ST_TX;
                        end else begin
                           r_next.long_match = 1'b0;
                        end
                     end else begin
                        r_next.long_match = 1'b0;
                     end
                  end else if (r_reg.fsm == ST_ADDR2) begin
                     // RULE_05: low byte compare
                     if (r_reg.shreg == r_reg.own[7:0]) begin
                        ack               = 1'b1;
                        r_next.long_match = 1'b1;
                        r_next.prior      = 1'b1;
                        r_next.after      = ST_RX;
                     end else begin
                        r_next.long_match = 1'b0;
                     end
                  end else begin
                     r_next.after = ST_RX;
                     r_next.fsm   = ST_ACK;
                     // RULE_19: overrun keeps old byte, no ack
                     if (r_reg.rx_full) begin
                        r_next.stat_hi[0] = 1'b1;
                     end else begin
                        // RULE_14: shift register into buffer
                        r_next.rxbuf   = r_reg.shreg;
                        r_next.rx_full = 1'b1;
                        r_next.sda_drv = ~r_reg.stat_hi[0];
                     end
                  end
                  if (ack) begin
                     r_next.fsm     = ST_ACK;
                     r_next.sda_drv = 1'b1;
                  end
               end
            end
            ST_ACK: begin
               // RULE_08: event at ninth falling edge
               if (scl_fall) begin
                  r_next.sda_drv = 1'b0;
                  r_next.ev      = 1'b1;
                  r_next.fsm     = r_reg.after;
                  r_next.bitcnt  = 4'h0;
                  // RULE_10: hold clock when transmit is empty, until the release bit is set again
                  if (r_reg.after == ST_TX) begin
                     rel_clr = ~r_reg.tx_full;
                  end
                  if (r_reg.after == ST_RX && r_reg.ctrl[CTRL_RX_STRETCH_ENABLE]) begin
                     rel_clr = r_reg.rx_full;
                  end
               end
            end
            ST_TX: begin
               // RULE_12: data moves only after falling edges
               r_next.sda_drv = ~r_reg.txr[7];
               if (scl_fall) begin
                  if (r_reg.bitcnt == LAST_TX_BIT) begin
                     r_next.fsm     = ST_TACK;
                     r_next.sda_drv = 1'b0;
                     r_next.tx_full = 1'b0;
                     r_next.bitcnt  = 4'h0;
                  end else begin
                     r_next.txr    = {r_reg.txr[6:0], 1'b0};
                     r_next.bitcnt = r_reg.bitcnt + 4'h1;
                  end
               end
            end
            ST_TACK: begin
               r_next.sda_drv = 1'b0;
               if (scl_rise) begin
                  r_next.nack = sda;
               end
               // RULE_13: event regardless of master ack
               if (scl_fall) begin
                  r_next.ev = 1'b1;
                  if (r_reg.nack) begin
                     r_next.fsm = ST_IDLE;
                  end else begin
                     r_next.fsm = ST_TX;
                     // RULE_20: after master ack, stretch on empty transmit
                     rel_clr = ~r_reg.tx_full;
                  end
               end
            end
         endcase
      end

      // RULE_15: single transmit register, write sets full
      if (wr_tx) begin
         r_next.txr     = BUS_I.wdata[7:0];
         r_next.tx_full = 1'b1;
      end
      if (rel_clr && !(wr_ctrl && BUS_I.wdata[CTRL_RELEASE])) begin
         r_next.ctrl[CTRL_RELEASE] = 1'b0;
      end

      // RULE_11: release after set, paced by bit-rate tick
      if (!r_reg.ctrl[CTRL_RELEASE] && !scl) begin
         r_next.scl_hold = 1'b1;
      end else if (r_reg.ctrl[CTRL_RELEASE] && brg_tick) begin
         r_next.scl_hold = 1'b0;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         r_reg            <= '0;
         r_reg.fsm        <= ST_IDLE;
         r_reg.after      <= ST_IDLE;
         r_reg.ctrl       <= CTRL_RESET;
         r_reg.stat_hi    <= STAT_RESET;
         r_reg.own        <= OWN_RESET;
         r_reg.baud       <= BAUD_RESET;
         r_reg.brg        <= BAUD_RESET;
         r_reg.scl_s      <= 3'h7;
         r_reg.sda_s      <= 3'h7;
      end else begin
         r_reg <= r_next;
      end
   end

   assign RDATA_O         = r_reg.rdata;
   assign SLV_EVENT_O     = r_reg.ev;
   // open drain: pins only ever pull low
   assign PINS_O = '{scl_o:    1'b0,
                     scl_oe_n: ~r_reg.scl_hold,
                     sda_o:    1'b0,
                     sda_oe_n: ~r_reg.sda_drv};

   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (SRST_I);

   property p_idle_wait;
      r_reg.fsm == ST_IDLE && !start_det |=> r_reg.fsm == ST_IDLE;
   endproperty
   a_idle_wait: assert property (p_idle_wait) // RULE_01
      else $error("left idle without start");

   property p_rise_sample;
      (r_reg.fsm == ST_ADDR || r_reg.fsm == ST_RX) && scl_rise &&
      r_reg.bitcnt != BITS_PER_BYTE && !start_det && !stop_det &&
      r_reg.ctrl[CTRL_ENABLE] |=> r_reg.shreg[0] == $past(sda);
   endproperty
   a_rise_sample: assert property (p_rise_sample) // RULE_02
      else $error("bit not sampled on rising clock");

   property p_short_match;
      r_reg.fsm == ST_ADDR && byte_end(scl_fall, r_reg.bitcnt) &&
      !start_det && !stop_det && r_reg.ctrl[CTRL_ENABLE] &&
      !r_reg.ctrl[CTRL_A10] && r_reg.shreg[7:1] == r_reg.own[6:0]
      |=> r_reg.fsm == ST_ACK && r_reg.sda_drv &&
          r_reg.rw == $past(r_reg.shreg[0]);
   endproperty
   a_short_match: assert property (p_short_match) // RULE_03
      else $error("seven-bit match not acknowledged");

   property p_low_byte_miss;
      r_reg.fsm == ST_ADDR2 && byte_end(scl_fall, r_reg.bitcnt) &&
      !start_det && !stop_det && r_reg.ctrl[CTRL_ENABLE] &&
      r_reg.shreg != r_reg.own[7:0]
      |=> r_reg.fsm == ST_IDLE && !r_reg.long_match;
   endproperty
   a_low_byte_miss: assert property (p_low_byte_miss) // RULE_05
      else $error("low byte mismatch not rejected");

   property p_event_ninth;
      r_reg.ev |-> $past(scl_fall) &&
         ($past(r_reg.fsm) == ST_ACK || $past(r_reg.fsm) == ST_TACK);
   endproperty
   a_event_ninth: assert property (p_event_ninth) // RULE_08
      else $error("event outside ninth falling edge");

   property p_addr_keeps_rx;
      (r_reg.fsm == ST_ADDR || r_reg.fsm == ST_ADDR2) && !rd_rx
      |=> $stable(r_reg.rx_full) && $stable(r_reg.rxbuf);
   endproperty
   a_addr_keeps_rx: assert property (p_addr_keeps_rx) // RULE_09
      else $error("address phase touched receive buffer");

   property p_tx_hold;
      r_reg.fsm == ST_TACK && scl_fall && !r_reg.nack && !r_reg.tx_full &&
      !wr_tx && !wr_ctrl && !start_det && !stop_det &&
      r_reg.ctrl[CTRL_ENABLE] |=> !r_reg.ctrl[CTRL_RELEASE];
   endproperty
   a_tx_hold: assert property (p_tx_hold) // RULE_20
      else $error("empty transmit not stretched");

   property p_tx_stable;
      r_reg.fsm == ST_TX && scl && !scl_fall && !wr_tx
      |=> $stable(r_reg.txr);
   endproperty
   a_tx_stable: assert property (p_tx_stable) // RULE_12
      else $error("transmit data moved while clock high");

   property p_overrun;
      r_reg.fsm == ST_RX && byte_end(scl_fall, r_reg.bitcnt) &&
      r_reg.rx_full && !start_det && !stop_det && r_reg.ctrl[CTRL_ENABLE]
      |=> !r_reg.sda_drv && $stable(r_reg.rxbuf) ##[1:300] r_reg.ev;
   endproperty
   a_overrun: assert property (p_overrun) // RULE_19
      else $error("overrun handling wrong");

   property p_rx_load;
      r_reg.fsm == ST_RX && byte_end(scl_fall, r_reg.bitcnt) &&
      !r_reg.rx_full && !start_det && !stop_det && r_reg.ctrl[CTRL_ENABLE]
      |=> r_reg.rx_full && r_reg.rxbuf == $past(r_reg.shreg);
   endproperty
   a_rx_load: assert property (p_rx_load) // RULE_14
      else $error("byte not moved to buffer");

   property p_reload;
      brg_tick |=> r_reg.brg == $past(r_reg.baud);
   endproperty
   a_reload: assert property (p_reload) // RULE_18
      else $error("bit-rate counter not reloaded");

   c_read_addr: cover property (r_reg.fsm == ST_ACK ##1 r_reg.fsm == ST_TX);
   c_long_done: cover property ($rose(r_reg.long_match));
   c_overrun: cover property ($rose(r_reg.stat_hi[0]));

endmodule

`default_nettype wire

//--- include/i2cs_pkg.sv
package i2cs_pkg;

   // register indices on the plain register port
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STAT = 4'h1;
   localparam logic [3:0] REG_OWN  = 4'h2;
   localparam logic [3:0] REG_BAUD = 4'h3;
   localparam logic [3:0] REG_TX   = 4'h4;
   localparam logic [3:0] REG_RX   = 4'h5;

   // bus_control bit positions
   localparam int CTRL_ENABLE  = 15;
   localparam int CTRL_RELEASE = 12;
   localparam int CTRL_A10     = 10;
   localparam int CTRL_RX_STRETCH_ENABLE   = 6;

   // bus_status bit positions (5:0 read only)
   localparam int STAT_TBF    = 0;
   localparam int STAT_RBF    = 1;
   localparam int STAT_RW     = 2;
   localparam int STAT_LONG_ADDR_MATCHED  = 3;
   localparam int STAT_BUSY   = 4;
   localparam int STAT_NACK   = 5;
   localparam int STAT_RW_LSB = 6;

   // reset values
   localparam logic [15:0] CTRL_RESET = 16'h1000;
   localparam logic [9:0]  STAT_RESET = 10'h000;
   localparam logic [9:0]  OWN_RESET  = 10'h000;
   localparam logic [15:0] BAUD_RESET = 16'h0010;

   // protocol constants
   localparam logic [4:0] LONG_PREFIX   = 5'h1e;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] LAST_TX_BIT   = 4'h7;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0000,
      ST_ADDR  = 4'b0001,
      ST_ADDR2 = 4'b0010,
      ST_ACK   = 4'b0011,
      ST_RX    = 4'b0100,
      ST_TX    = 4'b0101,
      ST_TACK  = 4'b0110
   } i2cs_state_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [3:0]  addr;
      logic [15:0] wdata;
   } i2cs_req_t;

   typedef struct packed {
      logic scl_o;
      logic scl_oe_n;
      logic sda_o;
      logic sda_oe_n;
   } i2cs_pins_t;

   typedef struct packed {
      i2cs_state_t fsm;
      i2cs_state_t after;
      logic [3:0]  bitcnt;
      logic [7:0]  shreg;
      logic [7:0]  txr;
      logic [7:0]  rxbuf;
      logic [15:0] ctrl;
      logic [9:0]  stat_hi;
      logic [9:0]  own;
      logic [15:0] baud;
      logic [15:0] brg;
      logic        tx_full;
      logic        rx_full;
      logic        rw;
      logic        long_match;
      logic        prior;
      logic        nack;
      logic        sda_drv;
      logic        scl_hold;
      logic        ev;
      logic [15:0] rdata;
      logic [2:0]  scl_s;
      logic [2:0]  sda_s;
   } i2cs_st_t;

endpackage

//--- testbench/i2cs_master_model.sv
`timescale 1ns/10ps
`default_nettype none

module i2cs_master_model (
   input  wire logic CLK_I,
   input  wire logic SCL_I,
   input  wire logic SDA_I,
   output logic      SCL_OE_N_O,
   output logic      SDA_OE_N_O
);
   // half of the 80 ns link clock period
   localparam int HALF = 5;
   int            stall_count = 0;

   initial begin
      SCL_OE_N_O = 1'b1;
      SDA_OE_N_O = 1'b1;
   end

   task automatic half_bit();
      repeat (HALF) @(posedge CLK_I);
   endtask

   task automatic scl_rise();
      int n;
      n = 0;
      SCL_OE_N_O <= 1'b1;
      @(posedge CLK_I);
      while (SCL_I !== 1'b1 && n < 4000) begin
         @(posedge CLK_I);
         n++;
      end
      if (n >= 4000)
         stall_count++;
   endtask

   task automatic xfer_bit(input logic b, output logic s, output logic stb);
      @(posedge CLK_I);
      SDA_OE_N_O <= b;
      half_bit();
      scl_rise();
      s = SDA_I;
      half_bit();
      stb = (SDA_I === s);
      SCL_OE_N_O <= 1'b0;
   endtask

   task automatic start();
      @(posedge CLK_I);
      SDA_OE_N_O <= 1'b1;
      half_bit();
      scl_rise();
      half_bit();
      SDA_OE_N_O <= 1'b0;
      half_bit();
      SCL_OE_N_O <= 1'b0;
   endtask

   task automatic stop();
      @(posedge CLK_I);
      SDA_OE_N_O <= 1'b0;
      half_bit();
      scl_rise();
      half_bit();
      SDA_OE_N_O <= 1'b1;
      half_bit();
   endtask

   task automatic write_byte(input logic [7:0] d, output logic ack);
      logic s;
      logic stb;
      for (int i = 7; i >= 0; i--)
         xfer_bit(d[i], s, stb);
      xfer_bit(1'b1, s, stb);
      ack = ~s;
      half_bit();
   endtask

   task automatic read_byte(input logic nack, output logic [7:0] d,
                            output logic ok);
      logic s;
      logic stb;
      ok = 1'b1;
      for (int i = 7; i >= 0; i--) begin
         xfer_bit(1'b1, s, stb);
         d[i] = s;
         ok = ok & stb;
      end
      xfer_bit(nack, s, stb);
      half_bit();
   endtask
endmodule

`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
   import i2cs_pkg::*;

   typedef struct packed {
      logic [3:0]  a;
      logic [15:0] d;
      logic [15:0] e;
   } i2cs_row_t;

   localparam i2cs_row_t ROWS [7] = '{
      '{REG_OWN,  16'h03ff, 16'h03ff},
      '{REG_BAUD, 16'h0001, 16'h0001},
      '{REG_STAT, 16'hffff, 16'hffc0},
      '{REG_STAT, 16'h0000, 16'h0000},
      '{REG_CTRL, 16'h0455, 16'h1455},
      '{REG_CTRL, 16'h0055, 16'h0055},
      '{4'hf,     16'h1234, 16'h0000}
   };

   logic        clk;
   logic        srst = 1'b1;
   i2cs_req_t   bus = '0;
   logic [15:0] rdata;
   i2cs_pins_t  pins;
   logic        slv_ev;
   logic        m_scl_oe_n;
   logic        m_sda_oe_n;
   logic        scl_w;
   logic        sda_w;
   int          n_errors = 0;
   int          cmp_count = 0;
   int          ev_count = 0;
   int          cycles = 0;

   // open-drain wires with pull-ups
   assign scl_w = m_scl_oe_n & pins.scl_oe_n;
   assign sda_w = m_sda_oe_n & pins.sda_oe_n;

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   i2cs_slave i_i2cs_slave (
      .CLOCK_I     (clk),
      .SRST_I      (srst),
      .BUS_I       (bus),
      .RDATA_O     (rdata),
      .SCL_I       (scl_w),
      .SDA_I       (sda_w),
      .PINS_O      (pins),
      .SLV_EVENT_O (slv_ev)
   );

   i2cs_master_model i_i2cs_master_model (
      .CLK_I      (clk),
      .SCL_I      (scl_w),
      .SDA_I      (sda_w),
      .SCL_OE_N_O (m_scl_oe_n),
      .SDA_OE_N_O (m_sda_oe_n)
   );

   task automatic summarize();
      if (i_i2cs_master_model.stall_count != 0)
         n_errors++;
      $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (slv_ev === 1'b1)
         ev_count <= ev_count + 1;
      if (cycles == 20000) begin
         $display("mismatch at %0t: run timed out", $time);
         n_errors++;
         summarize();
      end
   end

   task automatic check16(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: word %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
      end
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      bus.wr <= 1'b1;
      bus.addr <= a;
      bus.wdata <= d;
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      bus.rd <= 1'b1;
      bus.addr <= a;
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic expect_rd(input logic [3:0] a, input logic [15:0] e);
      logic [15:0] d;
      reg_rd(a, d);
      check16(d, e);
   endtask

   task automatic send(input logic [7:0] b, input logic ack_e, input int ev_e);
      logic ack;
      int   e0;
      e0 = ev_count;
      i_i2cs_master_model.write_byte(b, ack);
      repeat (3) @(posedge clk);
      #1;
      check_bit(ack, ack_e);
      check16(16'(ev_count - e0), 16'(ev_e));
   endtask

   task automatic serve(input logic [15:0] ctrl, input logic [7:0] d);
      logic [15:0] s;
      repeat (20) @(posedge clk);
      #1;
      check_bit(pins.scl_oe_n, 1'b0);
      reg_wr(REG_TX, {8'h00, d});
      reg_rd(REG_STAT, s);
      check_bit(s[STAT_TBF], 1'b1);
      check_bit(s[STAT_RW], 1'b1);
      check_bit(pins.scl_oe_n, 1'b0);
      reg_wr(REG_CTRL, ctrl);
   endtask

   task automatic fetch(input logic nack, input logic [7:0] e);
      logic [7:0] d;
      logic       ok;
      int         e0;
      e0 = ev_count;
      i_i2cs_master_model.read_byte(nack, d, ok);
      repeat (3) @(posedge clk);
      #1;
      check16({8'h00, d}, {8'h00, e});
      check_bit(ok, 1'b1);
      check16(16'(ev_count - e0), 16'h0001);
   endtask

   initial begin
      logic [15:0] s;
      repeat (4) @(posedge clk);
      check_bit(pins.scl_oe_n, 1'b1);
      check_bit(pins.sda_oe_n, 1'b1);
      check_bit(pins.scl_o, 1'b0);
      check_bit(pins.sda_o, 1'b0);
      srst <= 1'b0;
      expect_rd(REG_CTRL, CTRL_RESET);
      @(posedge clk);
      #1;
      check16(rdata, 16'h0000);
      expect_rd(REG_STAT, {STAT_RESET, 6'h00});
      expect_rd(REG_OWN, {6'h00, OWN_RESET});
      expect_rd(REG_BAUD, BAUD_RESET);
      foreach (ROWS[i]) begin
         reg_wr(ROWS[i].a, ROWS[i].d);
         expect_rd(ROWS[i].a, ROWS[i].e);
      end
      reg_wr(REG_CTRL, 16'h9000);
      reg_wr(REG_OWN, 16'h0055);
      i_i2cs_master_model.start();
      send(8'haa, 1'b1, 1);
      reg_rd(REG_STAT, s);
      check_bit(s[STAT_RBF], 1'b0);
      send(8'ha5, 1'b1, 1);
      expect_rd(REG_RX, 16'h00a5);
      send(8'h3c, 1'b1, 1);
      send(8'hc3, 1'b0, 1);
      expect_rd(REG_RX, 16'h003c);
      reg_rd(REG_STAT, s);
      check_bit(s[STAT_RW_LSB], 1'b1);
      reg_wr(REG_STAT, 16'h0000);
      // receive stretch: full buffer holds the clock
      reg_wr(REG_CTRL, 16'h9040);
      send(8'h11, 1'b1, 1);
      repeat (20) @(posedge clk);
      #1;
      check_bit(pins.scl_oe_n, 1'b0);
      expect_rd(REG_RX, 16'h0011);
      reg_wr(REG_CTRL, 16'h9000);
      i_i2cs_master_model.stop();
      i_i2cs_master_model.start();
      send(8'hac, 1'b0, 0);
      i_i2cs_master_model.stop();
      i_i2cs_master_model.start();
      send(8'hab, 1'b1, 1);
      serve(16'h9000, 8'h96);
      fetch(1'b0, 8'h96);
      serve(16'h9000, 8'h69);
      fetch(1'b1, 8'h69);
      i_i2cs_master_model.stop();
      reg_wr(REG_OWN, 16'h02a7);
      reg_wr(REG_CTRL, 16'h9400);
      i_i2cs_master_model.start();
      send(8'hf4, 1'b1, 1);
      send(8'ha7, 1'b1, 1);
      reg_rd(REG_STAT, s);
      check_bit(s[STAT_LONG_ADDR_MATCHED], 1'b1);
      i_i2cs_master_model.start();
      send(8'hf5, 1'b1, 1);
      serve(16'h9400, 8'h5a);
      fetch(1'b1, 8'h5a);
      i_i2cs_master_model.stop();
      i_i2cs_master_model.start();
      send(8'hf4, 1'b1, 1);
      send(8'ha6, 1'b0, 0);
      i_i2cs_master_model.stop();
      reg_rd(REG_STAT, s);
      check_bit(s[STAT_NACK], 1'b1);
      check_bit(s[STAT_BUSY], 1'b0);
      // reset again in mid-run
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      expect_rd(REG_CTRL, CTRL_RESET);
      expect_rd(REG_OWN, {6'h00, OWN_RESET});
      summarize();
   end
endmodule

`default_nettype wire
